// >>> hdl/anc_packet_insert_ack.sv
// Overview of operation
// - With acknowledgement on, each inserted packet is acknowledged once.
// - Acknowledgement leaves only once the data is placed in the video.
// - With heartbeat on, a heartbeat packet goes out every two seconds.
// - Line field zero picks the configured line, else the packet's line.
// - Acknowledgement echoes header with type AC73B938 and the line used.
// - Heartbeat is type word 20120831 then 28 reserved zero bytes.
`default_nettype none
module anc_packet_insert_ack #(
  // Heartbeat period in clock cycles; only a testbench shortens it.
  parameter int unsigned HB_CYC = anc_insert_pkg::HEARTBEAT_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ack_enable_i,
  input  wire logic        heartbeat_enable_i,
  input  wire logic [15:0] default_line_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_last_i,
  output logic             rx_ready_o,
  output logic             anc_start_o,
  output logic      [7:0]  anc_did_o,
  output logic      [7:0]  anc_sdid_o,
  output logic      [15:0] anc_line_o,
  output logic      [15:0] anc_count_o,
  output logic      [7:0]  anc_data_o,
  output logic             anc_valid_o,
  input  wire logic        anc_ready_i,
  input  wire logic        anc_done_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i
);
  typedef enum logic [2:0] {
    ST_HDR,
    ST_START,
    ST_PAYLOAD,
    ST_WAIT_DONE,
    ST_DROP
  } rx_state_e;

  rx_state_e   state;
  logic [15:0] bcnt;
  logic [31:0] type_word;
  logic [15:0] psize;
  logic [7:0]  did;
  logic [7:0]  sdid;
  logic [15:0] line_field;
  logic [15:0] pay_size;
  logic [31:0] uid;
  logic [15:0] pay_left;
  logic        rx_take;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic        ack_pending;
  logic        hb_pending;
  logic [31:0] hb_cnt;
  logic        tx_busy;
  logic        tx_is_ack;
  logic [4:0]  tx_idx;
  logic [7:0]  next_tx_byte;

  // Payload bytes are gated by FIFO space so the sender is stalled.
  assign rx_take = rx_valid_i && rx_ready_o;
  assign fifo_in_valid = (state == ST_PAYLOAD) && rx_take;
  assign fifo_out_ready = anc_ready_i && (state == ST_PAYLOAD
                          || state == ST_WAIT_DONE);

  anc_byte_fifo #(
    .WIDTH (anc_insert_pkg::BYTE_W),
    .DEPTH (anc_insert_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .in_data_i   (rx_data_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  always_comb begin
    case (state)
      // Holding the next header until its acknowledgement is out keeps the
      // echoed fields intact, at the cost of some input throughput.
      ST_HDR:     rx_ready_o = !ack_pending && !(tx_busy && tx_is_ack);
      ST_DROP:    rx_ready_o = 1'b1;
      ST_PAYLOAD: rx_ready_o = fifo_in_ready && (pay_left != 16'h0000);
      default:    rx_ready_o = 1'b0;
    endcase
  end

  // Header capture, byte by byte, little-endian fields.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      type_word  <= '0;
      psize      <= '0;
      did        <= '0;
      sdid       <= '0;
      line_field <= '0;
      pay_size   <= '0;
      uid        <= '0;
    end else if (state == ST_HDR && rx_take) begin
      if (bcnt < 16'(anc_insert_pkg::OFS_PSIZE_LO)) begin
        type_word <= {rx_data_i, type_word[31:8]};
      end else if (bcnt == 16'(anc_insert_pkg::OFS_PSIZE_LO)) begin
        psize[7:0] <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_PSIZE_HI)) begin
        psize[15:8] <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_DID)) begin
        did <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_SDID)) begin
        sdid <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_LINE_LO)) begin
        line_field[7:0] <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_LINE_HI)) begin
        line_field[15:8] <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_PAY_LO)) begin
        pay_size[7:0] <= rx_data_i;
      end else if (bcnt == 16'(anc_insert_pkg::OFS_PAY_HI)) begin
        pay_size[15:8] <= rx_data_i;
      end else begin
        uid <= {rx_data_i, uid[31:8]};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state    <= ST_HDR;
      bcnt     <= '0;
      pay_left <= '0;
    end else begin
      case (state)
        ST_HDR: begin
          if (rx_take) begin
            bcnt <= bcnt + 16'h0001;
            if (bcnt == 16'(anc_insert_pkg::OFS_UID3)) begin
              bcnt <= '0;
              if (type_word != anc_insert_pkg::TYPE_INSERT) begin
                state <= rx_last_i ? ST_HDR : ST_DROP;
              end else begin
                state <= ST_START;
              end
            end else if (rx_last_i) begin
              bcnt <= '0;
            end
          end
        end
        ST_START: begin
          pay_left <= pay_size;
          state    <= ST_PAYLOAD;
        end
        ST_PAYLOAD: begin
          if (rx_take) begin
            pay_left <= pay_left - 16'h0001;
          end
          if (pay_left == 16'h0000 || (rx_take && rx_last_i)) begin
            state <= ST_WAIT_DONE;
          end
        end
        ST_WAIT_DONE: begin
          if (anc_done_i && !fifo_out_valid) begin
            state <= ST_HDR;
          end
        end
        ST_DROP: begin
          if (rx_take && rx_last_i) begin
            state <= ST_HDR;
          end
        end
        default: state <= ST_HDR;
      endcase
    end
  end

  // Inserter command and registered data path.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      anc_start_o <= 1'b0;
      anc_did_o   <= '0;
      anc_sdid_o  <= '0;
      anc_line_o  <= '0;
      anc_count_o <= '0;
    end else begin
      anc_start_o <= (state == ST_START);
      if (state == ST_START) begin
        anc_did_o   <= did;
        anc_sdid_o  <= sdid;
        anc_count_o <= pay_size;
        anc_line_o  <= (line_field == 16'h0000) ? default_line_i
                                                : line_field;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      anc_data_o  <= '0;
      anc_valid_o <= 1'b0;
    end else begin
      anc_valid_o <= fifo_out_valid && fifo_out_ready;
      anc_data_o  <= fifo_out_data;
    end
  end

  // Pending flags: a new event wins over the clear by the sender.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ack_pending <= 1'b0;
    end else if (state == ST_WAIT_DONE && anc_done_i && !fifo_out_valid
                 && ack_enable_i) begin
      ack_pending <= 1'b1;
    end else if (!tx_busy && ack_pending) begin
      ack_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !heartbeat_enable_i) begin
      hb_cnt <= '0;
    end else if (hb_cnt == HB_CYC - 1) begin
      hb_cnt <= '0;
    end else begin
      hb_cnt <= hb_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hb_pending <= 1'b0;
    end else if (heartbeat_enable_i && hb_cnt == HB_CYC - 1) begin
      hb_pending <= 1'b1;
    end else if (!tx_busy && !ack_pending && hb_pending) begin
      hb_pending <= 1'b0;
    end
  end

  // Reply byte generator; acknowledgements take priority over heartbeats.
  always_comb begin
    next_tx_byte = 8'h00;
    if (tx_idx < 5'h04) begin
      next_tx_byte = tx_is_ack
        ? anc_insert_pkg::TYPE_ACK[8*tx_idx[1:0] +: 8]
        : anc_insert_pkg::TYPE_HEARTBEAT[8*tx_idx[1:0] +: 8];
    end else if (tx_is_ack) begin
      if (tx_idx == anc_insert_pkg::OFS_PSIZE_LO) begin
        next_tx_byte = psize[7:0];
      end else if (tx_idx == anc_insert_pkg::OFS_PSIZE_HI) begin
        next_tx_byte = psize[15:8];
      end else if (tx_idx == anc_insert_pkg::OFS_DID) begin
        next_tx_byte = did;
      end else if (tx_idx == anc_insert_pkg::OFS_SDID) begin
        next_tx_byte = sdid;
      end else if (tx_idx == anc_insert_pkg::OFS_LINE_LO) begin
        next_tx_byte = anc_line_o[7:0];
      end else if (tx_idx == anc_insert_pkg::OFS_LINE_HI) begin
        next_tx_byte = anc_line_o[15:8];
      end else if (tx_idx == anc_insert_pkg::OFS_PAY_LO) begin
        next_tx_byte = pay_size[7:0];
      end else if (tx_idx == anc_insert_pkg::OFS_PAY_HI) begin
        next_tx_byte = pay_size[15:8];
      end else if (tx_idx >= anc_insert_pkg::OFS_UID0
                   && tx_idx <= anc_insert_pkg::OFS_UID3) begin
        next_tx_byte = uid[8*tx_idx[1:0] +: 8];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_busy    <= 1'b0;
      tx_is_ack  <= 1'b0;
      tx_idx     <= '0;
      tx_data_o  <= '0;
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
    end else if (!tx_busy) begin
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
      if (ack_pending || hb_pending) begin
        tx_busy   <= 1'b1;
        tx_is_ack <= ack_pending;
        tx_idx    <= '0;
      end
    end else if (!tx_valid_o || tx_ready_i) begin
      if (tx_valid_o && tx_last_o) begin
        tx_busy    <= 1'b0;
        tx_valid_o <= 1'b0;
        tx_last_o  <= 1'b0;
      end else begin
        tx_data_o  <= next_tx_byte;
        tx_valid_o <= 1'b1;
        tx_last_o  <= (tx_idx == 5'(anc_insert_pkg::REPLY_BYTES - 1));
        tx_idx     <= tx_idx + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/anc_insert_pkg.sv
`default_nettype none
package anc_insert_pkg;
  localparam int unsigned  CLK_HZ         = 10_000_000;
  localparam int unsigned  HEARTBEAT_S    = 2;
  localparam int unsigned  HEARTBEAT_CYC  = HEARTBEAT_S * CLK_HZ;
  localparam logic [31:0]  TYPE_INSERT    = 32'hF5AB02ED;
  localparam logic [31:0]  TYPE_ACK       = 32'hAC73B938;
  localparam logic [31:0]  TYPE_HEARTBEAT = 32'h20120831;
  localparam int unsigned  HDR_BYTES      = 16;
  localparam int unsigned  REPLY_BYTES    = 32;
  localparam int unsigned  FIFO_DEPTH     = 16;
  localparam int unsigned  BYTE_W         = 8;
  localparam int unsigned  BCNT_W         = 16;
  // Header byte offsets of the insertion and acknowledgement packets.
  localparam logic [4:0]   OFS_PSIZE_LO   = 5'h04;
  localparam logic [4:0]   OFS_PSIZE_HI   = 5'h05;
  localparam logic [4:0]   OFS_DID        = 5'h06;
  localparam logic [4:0]   OFS_SDID       = 5'h07;
  localparam logic [4:0]   OFS_LINE_LO    = 5'h08;
  localparam logic [4:0]   OFS_LINE_HI    = 5'h09;
  localparam logic [4:0]   OFS_PAY_LO     = 5'h0A;
  localparam logic [4:0]   OFS_PAY_HI     = 5'h0B;
  localparam logic [4:0]   OFS_UID0       = 5'h0C;
  localparam logic [4:0]   OFS_UID3       = 5'h0F;
endpackage
`default_nettype wire

// >>> hdl/anc_byte_fifo.sv
`default_nettype none
module anc_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + AW'(1);
      end
      if (pop) begin
        rptr <= rptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/anc_ins_chk.sv
`default_nettype none
module anc_ins_chk (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        heartbeat_enable_i,
  input wire logic [15:0] default_line_i,
  input wire logic        anc_start_o,
  input wire logic [15:0] anc_line_o,
  input wire logic [15:0] anc_count_o,
  input wire logic        anc_valid_o,
  input wire logic        anc_done_i,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_last_o,
  input wire logic        tx_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0]  tx_n;
  logic [15:0] pay_n;
  logic [3:0]  since_done;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || (tx_valid_o && tx_ready_i && tx_last_o))
      tx_n <= '0;
    else if (tx_valid_o && tx_ready_i)
      tx_n <= tx_n + 6'h01;
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i || anc_start_o)
      pay_n <= '0;
    else if (anc_valid_o)
      pay_n <= pay_n + 16'h0001;
  end
  // Saturates so that a stale completion never looks recent.
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      since_done <= 4'hF;
    else if (anc_done_i)
      since_done <= 4'h0;
    else if (since_done != 4'hF)
      since_done <= since_done + 4'h1;
  end
  a_start_one_cycle: assert property (anc_start_o |=> !anc_start_o)
    else $error("insert command longer than one cycle");
  a_line_default: assert property (
    anc_start_o && default_line_i != 16'h0000 |-> anc_line_o != 16'h0000)
    else $error("line zero used");
  a_pay_bound: assert property (anc_valid_o |-> pay_n < anc_count_o)
    else $error("more payload bytes than counted");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o)) else $error("reply byte dropped");
  a_first_type: assert property (
    tx_valid_o && tx_n == 6'h00 |->
    tx_data_o == anc_insert_pkg::TYPE_ACK[7:0] ||
    tx_data_o == anc_insert_pkg::TYPE_HEARTBEAT[7:0])
    else $error("reply type byte wrong");
  a_last_at_32: assert property (tx_valid_o && tx_ready_i
    |-> tx_last_o == (tx_n == 6'h1F)) else $error("reply length wrong");
  a_ack_after_done: assert property (
    $rose(tx_valid_o) && tx_n == 6'h00 && !heartbeat_enable_i
    |-> since_done < 4'h6) else $error("ack not tied to completion");
  a_reserved_zero: assert property (
    tx_valid_o && tx_n >= 6'h10 |-> tx_data_o == 8'h00)
    else $error("reserved reply byte not zero");
endmodule
`default_nettype wire

// >>> tb/anc_sink_model.sv
`default_nettype none
module anc_sink_model (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        stall_i,
  input  wire logic        anc_start_i,
  input  wire logic [15:0] anc_count_i,
  input  wire logic        anc_valid_i,
  output logic             anc_ready_o,
  output logic             anc_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got;
  logic        busy;
  // Stalling only holds the FIFO back; the model never drops a byte.
  assign anc_ready_o = !stall_i;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      got        <= '0;
      busy       <= 1'b0;
      anc_done_o <= 1'b0;
    end else begin
      anc_done_o <= 1'b0;
      if (anc_start_i) begin
        got  <= '0;
        busy <= 1'b1;
      end else if (busy && got == anc_count_i) begin
        anc_done_o <= 1'b1;
        busy       <= 1'b0;
      end else if (anc_valid_i)
        got <= got + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HB_TEST = 200;
  typedef struct {
    logic ack; logic [31:0] ty; logic [15:0] line; logic [15:0] dflt;
    logic [15:0] n; logic stall; logic ins; logic [15:0] used;
  } row_s;
  // Payloads stay far below one native packet.
  row_s rows [5] = '{
    '{1'b1, 32'hF5AB02ED, 16'h0123, 16'h0015,
      16'h0003, 1'b0, 1'b1, 16'h0123},
    '{1'b1, 32'hF5AB02ED, 16'h0000, 16'h0015,
      16'h0001, 1'b0, 1'b1, 16'h0015},
    '{1'b1, 32'h12345678, 16'h0040, 16'h0015,
      16'h0002, 1'b0, 1'b0, 16'h0000},
    '{1'b0, 32'hF5AB02ED, 16'h0007, 16'h0015,
      16'h0000, 1'b0, 1'b1, 16'h0007},
    '{1'b1, 32'hF5AB02ED, 16'h0000, 16'h0233,
      16'h0014, 1'b1, 1'b1, 16'h0233}};
  logic        core_clk_i = 1'b0, srst_i = 1'b1, ack_enable_i = 1'b0;
  logic        rx_valid_i = 1'b0, rx_last_i = 1'b0, tx_ready_i = 1'b0;
  logic        stall = 1'b0, anc_start_o, anc_valid_o, anc_ready_i;
  logic        anc_done_i, tx_valid_o, tx_last_o, rx_ready_o;
  // Heartbeat starts off; its own test runs with a shortened period.
  logic        heartbeat_enable_i = 1'b0;
  logic [15:0] default_line_i = '0, anc_line_o, anc_count_o, line_s, cnt_s;
  logic [7:0]  rx_data_i = '0, anc_did_o, anc_sdid_o, anc_data_o, tx_data_o;
  logic [7:0]  pay_q [$], tx_q [$];
  logic [7:0]  did_s, sdid_s;
  logic [127:0] h;
  int          n_fail = 0, checked = 0, n_start, r, k;
  anc_packet_insert_ack #(.HB_CYC(HB_TEST)) dut (.core_clk_i, .srst_i,
    .ack_enable_i, .heartbeat_enable_i, .default_line_i, .rx_data_i,
    .rx_valid_i,
    .rx_last_i, .rx_ready_o, .anc_start_o, .anc_did_o, .anc_sdid_o,
    .anc_line_o, .anc_count_o, .anc_data_o, .anc_valid_o, .anc_ready_i,
    .anc_done_i, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i);
  anc_sink_model sink (.core_clk_i, .srst_i, .stall_i(stall),
    .anc_start_i(anc_start_o), .anc_count_i(anc_count_o),
    .anc_valid_i(anc_valid_o), .anc_ready_o(anc_ready_i),
    .anc_done_o(anc_done_i));
  always #50 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) tx_ready_i <= ~tx_ready_i;
  always @(posedge core_clk_i) begin
    if (anc_start_o) begin
      n_start++;
      line_s = anc_line_o;
      cnt_s = anc_count_o;
      did_s = anc_did_o;
      sdid_s = anc_sdid_o;
    end
    if (anc_valid_o) pay_q.push_back(anc_data_o);
    if (tx_valid_o && tx_ready_i) tx_q.push_back(tx_data_o);
  end
  task automatic results();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic last);
    int i;
    rx_data_i = b;
    rx_last_i = last;
    rx_valid_i = 1'b1;
    for (i = 0; i < 500; i++) begin
      #1;
      if (rx_ready_o === 1'b1) break;
      @(negedge core_clk_i);
    end
    if (i == 500) begin
      n_fail++;
      $display("[ERR] %0t input never accepted", $time);
      results();
    end
    @(negedge core_clk_i);
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    chk(anc_start_o, 1'b0);
    chk(tx_valid_o, 1'b0);
    srst_i = 1'b0;
    @(negedge core_clk_i);
    chk(rx_ready_o, 1'b1);
    for (r = 0; r < 5; r++) begin
      ack_enable_i = rows[r].ack;
      default_line_i = rows[r].dflt;
      stall = rows[r].stall;
      n_start = 0;
      pay_q.delete();
      tx_q.delete();
      if (rows[r].stall) fork
        begin
          repeat (60) @(negedge core_clk_i);
          stall = 1'b0;
        end
      join_none
      h = {32'hC0DE0000 + r, rows[r].n, rows[r].line, 8'h02, 8'h61,
           rows[r].n + 16'h0010, rows[r].ty};
      for (k = 0; k < 16; k++) put(h[8*k+:8], k == 15 && rows[r].n == 0);
      for (k = 0; k < rows[r].n; k++) put(8'hA0 + k, k == rows[r].n - 1);
      rx_valid_i = 1'b0;
      for (k = 0; k < 300 && tx_q.size() < 32; k++) @(negedge core_clk_i);
      chk(n_start, rows[r].ins);
      if (rows[r].ins) begin
        chk(line_s, rows[r].used);
        chk(cnt_s, rows[r].n);
        chk(did_s, 8'h61);
        chk(sdid_s, 8'h02);
        chk(pay_q.size(), rows[r].n);
        foreach (pay_q[i]) chk(pay_q[i], 8'hA0 + i);
      end
      chk(tx_q.size(), rows[r].ins && rows[r].ack ? 32 : 0);
      h[31:0] = anc_insert_pkg::TYPE_ACK;
      h[79:64] = rows[r].used;
      foreach (tx_q[i]) chk(tx_q[i], i < 16 ? h[8*i+:8] : 8'h00);
    end
    // Heartbeat twice; a reset in mid-run must restart its timer.
    heartbeat_enable_i = 1'b1;
    h[31:0] = anc_insert_pkg::TYPE_HEARTBEAT;
    for (r = 0; r < 2; r++) begin
      tx_q.delete();
      for (k = 0; k < 2 * HB_TEST && !tx_valid_o; k++) @(negedge core_clk_i);
      chk(k, HB_TEST + 2);
      for (k = 0; k < 300 && tx_q.size() < 32; k++) @(negedge core_clk_i);
      chk(tx_q.size(), 32);
      foreach (tx_q[i]) chk(tx_q[i], i < 4 ? h[8*i+:8] : 8'h00);
      srst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk(tx_valid_o, 1'b0);
      chk(anc_valid_o, 1'b0);
      srst_i = 1'b0;
    end
    results();
  end
endmodule
bind anc_packet_insert_ack anc_ins_chk chk (.core_clk_i, .srst_i,
  .heartbeat_enable_i, .default_line_i, .anc_start_o, .anc_line_o,
  .anc_count_o, .anc_valid_o, .anc_done_i, .tx_data_o, .tx_valid_o,
  .tx_last_o, .tx_ready_i);
`default_nettype wire
